// >>> rtl/bci_defs.svh
// register map, field positions, reset values and timing counts of the cipher register block
`ifndef BCI_DEFS_SVH
`define BCI_DEFS_SVH
`define BCI_ADDR_STATUS 8'h82
`define BCI_ADDR_CTRL 8'h83
`define BCI_ADDR_WIN_LO 8'h84
`define BCI_ADDR_WIN_HI 8'h93
`define BCI_ADDR_MIRROR 8'h94
`define BCI_ST_ERR_BIT 7
`define BCI_ST_DONE_BIT 0
`define BCI_CT_REQ_BIT 7
`define BCI_CT_MODE_MSB 6
`define BCI_CT_MODE_LSB 4
`define BCI_CT_DIR_BIT 3
`define BCI_MODE_RST 3'h0
`define BCI_DIR_RST 1'b0
`define BCI_RDATA_RST 8'h00
`define BCI_BLK_RST 128'h0
`define BCI_RMASK_FULL 16'hFFFF
`define BCI_RUN_TIME_US 24
`define BCI_CLK_MHZ 200
`define BCI_LAST_ROUND 4'hA
`endif

// >>> rtl/bci_pkg.sv
// types shared by the cipher register block and its round engine
package bci_pkg;
    typedef enum logic [2:0] {
        BCI_MODE_ECB = 3'h0,
        BCI_MODE_KEY = 3'h1,
        BCI_MODE_CBC = 3'h2
    } bci_mode_t;
    typedef enum logic [1:0] {
        BCI_FSM_IDLE = 2'b01,
        BCI_FSM_RUN = 2'b10
    } bci_fsm_t;
    typedef struct packed {
        logic [127:0] st;
        logic [127:0] rk;
        logic [3:0] rnd;
        logic dec;
        logic busy;
        logic fin;
    } bci_core_t;
    typedef struct packed {
        bci_fsm_t fsm;
        logic [2:0] mode;
        logic dir;
        logic err;
        logic done;
        logic [127:0] key;
        logic [127:0] lastkey;
        logic [127:0] data;
        logic [127:0] prev;
        logic [12:0] cnt;
        logic [15:0] rmask;
        logic [7:0] rdata;
        logic start;
        logic abort;
    } bci_regs_t;
endpackage

// >>> rtl/bci_core.sv
// iterative 128-bit key block cipher engine, one round per clock
`timescale 1ns/10ps
`default_nettype none
`include "bci_defs.svh"
module bci_core
    import bci_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic dec_i,
    input wire logic [127:0] key_i,
    input wire logic [127:0] blk_i,
    output logic [127:0] res_o,
    output logic [127:0] rkey_o,
    output logic fin_o
);
    ////////////////////////////////////////////////////////////////////////
    // field arithmetic
    function automatic logic [7:0] xt(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
    endfunction
    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h00;
        p = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) r = r ^ p;
            p = xt(p);
        end
        return r;
    endfunction
    // inverse as a^254; costs area but needs no table
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h01;
        p = a;
        for (int i = 0; i < 8; i++) begin
            if (i != 0) r = gm(r, p);
            p = gm(p, p);
        end
        return r;
    endfunction
    function automatic logic [7:0] rl(input logic [7:0] x, input int n);
        logic [15:0] t;
        t = {x, x} << n;
        return t[15:8];
    endfunction
    function automatic logic [7:0] sb(input logic [7:0] a, input logic inv);
        logic [7:0] b;
        b = 8'h00;
        if (inv) begin
            b = ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
        end else begin
            b = ginv(a);
            b = b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
        end
        return b;
    endfunction
    function automatic logic [7:0] rcon(input logic [3:0] n);
        logic [7:0] r;
        r = 8'h01;
        for (int i = 2; i <= 10; i++) begin
            if (i <= int'(n)) r = xt(r);
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // block transforms; byte 0 is the most significant byte, column major
    function automatic logic [127:0] sub_shift(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        int src;
        o = '0;
        for (int i = 0; i < 16; i++) begin
            src = inv ? (((i / 4) + 4 - (i % 4)) % 4) * 4 + i % 4 : (((i / 4) + (i % 4)) % 4) * 4 + i % 4;
            o[127 - 8 * i -: 8] = sb(s[127 - 8 * src -: 8], inv);
        end
        return o;
    endfunction
    function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        logic [31:0] m;
        logic [7:0] acc;
        o = '0;
        m = inv ? 32'h0E0B0D09 : 32'h02030101;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                acc = 8'h00;
                for (int k = 0; k < 4; k++) begin
                    acc = acc ^ gm(m[31 - 8 * ((k - r + 4) % 4) -: 8], s[127 - 8 * (4 * c + k) -: 8]);
                end
                o[127 - 8 * (4 * c + r) -: 8] = acc;
            end
        end
        return o;
    endfunction
    function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
        return {sb(w[23:16], 1'b0) ^ rc, sb(w[15:8], 1'b0), sb(w[7:0], 1'b0), sb(w[31:24], 1'b0)};
    endfunction
    function automatic logic [127:0] key_step(input logic [127:0] k, input logic [7:0] rc, input logic back);
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
        {w0, w1, w2, w3} = k;
        if (back) begin
            w3 = w3 ^ w2;
            w2 = w2 ^ w1;
            w1 = w1 ^ w0;
            w0 = w0 ^ subrot(w3, rc);
        end else begin
            w0 = w0 ^ subrot(w3, rc);
            w1 = w1 ^ w0;
            w2 = w2 ^ w1;
            w3 = w3 ^ w2;
        end
        return {w0, w1, w2, w3};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    bci_core_t q;
    bci_core_t d;
    logic [127:0] nk;
    logic [127:0] s2;
    // one round per cycle; decryption walks the schedule backwards from the last round key
    always_comb begin
        d = q;
        nk = key_step(q.rk, rcon(q.dec ? 4'(11 - q.rnd) : q.rnd), q.dec);
        s2 = sub_shift(q.st, q.dec);
        if (abort_i) begin
            d.busy = 1'b0;
            d.fin = 1'b0;
        end else if (start_i) begin
            d.st = blk_i ^ key_i;
            d.rk = key_i;
            d.rnd = 4'h1;
            d.dec = dec_i;
            d.busy = 1'b1;
            d.fin = 1'b0;
        end else if (q.busy) begin
            if (q.dec) begin
                s2 = s2 ^ nk;
                d.st = (q.rnd == `BCI_LAST_ROUND) ? s2 : mix(s2, 1'b1);
            end else begin
                d.st = ((q.rnd == `BCI_LAST_ROUND) ? s2 : mix(s2, 1'b0)) ^ nk;
            end
            d.rk = nk;
            d.rnd = 4'(q.rnd + 4'h1);
            if (q.rnd == `BCI_LAST_ROUND) begin
                d.busy = 1'b0;
                d.fin = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign res_o = q.st;
    assign rkey_o = q.rk;
    assign fin_o = q.fin;

    property p_core_ten_rounds;
        @(posedge mclk_i) disable iff (!rst_n_i)
        // ten quiet round cycles, split in two runs to keep each repetition short
        (start_i && !abort_i) ##1 (!abort_i && !start_i) [*5] ##1 (!abort_i && !start_i) [*5] |=> fin_o;
    endproperty
    a_core_ten_rounds: assert property (p_core_ten_rounds) else $error("engine not finished after ten rounds");
endmodule
`default_nettype wire

// >>> rtl/bci_top.sv
// register interface of the block cipher: status, control, key/data window, control copy
//
// Overview of operation
// - window bytes hit the key in key mode, the data block in ECB or CBC
// - the address after the window behaves exactly like the control register
// - entering sleep returns every register to its reset state
// - registers are reached only through the SRAM-style read and write access
// - error flag sets on control access during a run or short data read
// - status bit 0 reads 1 once the run finished, 0 before
// - status is read-only, bits 6..1 read zero, writes ignored
// - any control access before the run finished aborts the run
// - writing 1 to control bit 7 starts a run in ECB or CBC mode; bit reads 0 when idle
// - control bits 6..4 pick ECB, key loading or CBC; 3..7 reserved
// - control bit 3 picks encrypt (0) or decrypt (1); bits 2..0 reserved
// - done sets when the 24 us run time has elapsed
// - each access returns the addressed register's previous content one byte later
// - key reads give the last round key after encryption, round key 0 after decryption; the written key stays for next run
// - CBC runs XOR new data with the previous result before ciphering
`timescale 1ns/10ps
`default_nettype none
`include "bci_defs.svh"
module bci_top
    import bci_pkg::*;
#(
    parameter int RUN_CYCLES = `BCI_RUN_TIME_US * `BCI_CLK_MHZ
)
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic sleep_i,
    input wire logic sram_we_i,
    input wire logic sram_re_i,
    input wire logic acc_end_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    output logic busy_o
);
    bci_regs_t q;
    bci_regs_t d;
    logic acc;
    logic is_ctl;
    logic in_win;
    logic [3:0] idx;
    logic [7:0] old;
    logic [7:0] ctl_byte;
    logic [2:0] wmode;
    logic run;
    logic [127:0] blk;
    logic [127:0] core_res;
    logic [127:0] core_rkey;
    logic core_fin;

    ////////////////////////////////////////////////////////////////////////
    // address decode; the control copy decodes like the control register
    assign acc = sram_we_i | sram_re_i;
    assign is_ctl = (addr_i == `BCI_ADDR_CTRL) || (addr_i == `BCI_ADDR_MIRROR);
    assign in_win = (addr_i >= `BCI_ADDR_WIN_LO) && (addr_i <= `BCI_ADDR_WIN_HI);
    assign idx = 4'(addr_i - `BCI_ADDR_WIN_LO);
    assign run = (q.fsm == BCI_FSM_RUN);
    assign wmode = wdata_i[`BCI_CT_MODE_MSB:`BCI_CT_MODE_LSB];
    // request bit shows the run state, so it reads 0 whenever the fsm is in BCI_FSM_IDLE
    assign ctl_byte = {run, q.mode, q.dir, 3'h0};
    // chaining input prepared here so the engine stays mode agnostic
    assign blk = (q.mode == BCI_MODE_CBC) ? (q.data ^ q.prev) : q.data;

    // previous content of the addressed byte, returned one byte behind
    always_comb begin
        old = `BCI_RDATA_RST;
        if (addr_i == `BCI_ADDR_STATUS) begin
            old[`BCI_ST_ERR_BIT] = q.err;
            old[`BCI_ST_DONE_BIT] = q.done;
        end else if (is_ctl) begin
            old = ctl_byte;
        end else if (in_win) begin
            old = (q.mode == BCI_MODE_KEY) ? q.lastkey[127 - 8 * idx -: 8] : q.data[127 - 8 * idx -: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register update
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.abort = 1'b0;
        if (acc) begin
            d.rdata = old;
        end
        // run timer; the done flag waits for the engine too, so a short timer of two or more cycles is safe
        if (run) begin
            if (q.cnt != 13'(RUN_CYCLES - 1)) begin
                d.cnt = 13'(q.cnt + 13'h1);
            end else if (core_fin) begin
                d.done = 1'b1;
                d.fsm = BCI_FSM_IDLE;
                d.data = core_res;
                d.prev = core_res;
                d.lastkey = core_rkey;
            end
        end
        if (acc && is_ctl && run) begin
            d.abort = 1'b1;
            d.fsm = BCI_FSM_IDLE;
            d.cnt = 13'h0;
            d.done = 1'b0;
        end else if (sram_we_i && is_ctl) begin
            d.mode = wmode;
            d.dir = wdata_i[`BCI_CT_DIR_BIT];
            // key mode and reserved modes only configure, they never launch
            if (wdata_i[`BCI_CT_REQ_BIT] && (wmode == BCI_MODE_ECB || wmode == BCI_MODE_CBC)) begin
                d.start = 1'b1;
                d.fsm = BCI_FSM_RUN;
                d.cnt = 13'h0;
                d.done = 1'b0;
                d.err = 1'b0;
            end
        end else if (sram_we_i && in_win) begin
            if (q.mode == BCI_MODE_KEY) begin
                d.key[127 - 8 * idx -: 8] = wdata_i;
            end else begin
                d.data[127 - 8 * idx -: 8] = wdata_i;
            end
        end else if (sram_re_i && in_win && q.mode != BCI_MODE_KEY) begin
            d.rmask[idx] = 1'b1;
        end
        // partial readout is judged when the access ends
        if (acc_end_i) begin
            d.rmask = 16'h0;
        end
        // error sets follow the start clear so only a sleep in the same cycle can hide them
        if (acc && is_ctl && run) begin
            d.err = 1'b1;
        end
        if (acc_end_i && q.rmask != 16'h0 && q.rmask != `BCI_RMASK_FULL) begin
            d.err = 1'b1;
        end
        if (sleep_i) begin
            d = '0;
            d.fsm = BCI_FSM_IDLE;
            d.abort = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.fsm <= BCI_FSM_IDLE;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    // one-hot run bit, so the pin comes straight from the state flop
    assign busy_o = q.fsm[1];

    ////////////////////////////////////////////////////////////////////////
    // round engine, launched one cycle after the start write
    bci_core u_core (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .start_i(q.start),
        .abort_i(q.abort),
        .dec_i(q.dir),
        .key_i(q.key),
        .blk_i(blk),
        .res_o(core_res),
        .rkey_o(core_rkey),
        .fin_o(core_fin)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_key_write;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sram_we_i && in_win && q.mode == BCI_MODE_KEY && !run && !sleep_i) |=> $stable(q.data);
    endproperty
    a_key_write: assert property (p_key_write) else $error("key-mode window write changed data");

    property p_mirror_read;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sram_re_i && addr_i == `BCI_ADDR_MIRROR && !run) |=> rdata_o == {1'b0, $past(q.mode), $past(q.dir), 3'h0};
    endproperty
    a_mirror_read: assert property (p_mirror_read) else $error("control copy read differs from control");

    property p_sleep_clear;
        @(posedge mclk_i) disable iff (!rst_n_i)
        sleep_i |=> (!q.done && !q.err && q.key == `BCI_BLK_RST && !busy_o);
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("sleep left state behind");

    property p_busy_access;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (acc && is_ctl && run && !sleep_i) |=> (q.err && !busy_o) ##1 !core_fin;
    endproperty
    a_busy_access: assert property (p_busy_access) else $error("control access during run not flagged");

    property p_done_time;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $rose(q.done) |-> ($past(q.cnt) == 13'(RUN_CYCLES - 1) && $past(run));
    endproperty
    a_done_time: assert property (p_done_time) else $error("done before run time elapsed");

    property p_status_ro;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sram_we_i && addr_i == `BCI_ADDR_STATUS && !run && !acc_end_i && !sleep_i) |=> $stable(q.err) && $stable(q.done);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed status");

    property p_start;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sram_we_i && is_ctl && !run && !sleep_i && wdata_i[`BCI_CT_REQ_BIT] && wmode == BCI_MODE_ECB)
            |=> (busy_o && !q.done && q.start);
    endproperty
    a_start: assert property (p_start) else $error("start write did not launch a run");

    property p_echo;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (acc && in_win && q.mode != BCI_MODE_KEY && !run && !sleep_i) |=> rdata_o == $past(q.data[127 - 8 * idx -: 8]);
    endproperty
    a_echo: assert property (p_echo) else $error("window byte not echoed one byte behind");
endmodule
`default_nettype wire

// >>> dv/bci_host_model.sv
// host side model: serial SRAM-style byte accesses to the cipher registers
`timescale 1ns/10ps
`default_nettype none
module bci_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    output var logic sram_we_o,
    output var logic sram_re_o,
    output var logic acc_end_o,
    output var logic [7:0] addr_o,
    output var logic [7:0] wdata_o
);
    ////////////////////////////////////////////////////////////////////////////
    // idle lines from time zero, no access open
    initial begin
        sram_we_o = 1'b0;
        sram_re_o = 1'b0;
        acc_end_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // one byte of an open access; caller sits just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        sram_we_o = wr;
        sram_re_o = ~wr;
        addr_o = a;
        wdata_o = wr ? d : ~wdata_o; // no stale data left on a read
        @(posedge mclk_i);
        #1;
        q = rdata_i;
    endtask

    // end of access; released lines flip so a stale value is never seen
    task automatic close_acc();
        sram_we_o = 1'b0;
        sram_re_o = 1'b0;
        acc_end_o = 1'b1;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
        @(posedge mclk_i);
        #1;
        acc_end_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the cipher register block with a host access model
`timescale 1ns/10ps
`default_nettype none
`include "bci_defs.svh"
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("wrong value at %0t ns: got %0h expected %0h", $time, (got), (exp)); \
        end \
    end
module tb;
    localparam int RUN = 16;
    localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    localparam logic [127:0] LRK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sleep_i = 1'b0;
    logic sram_we;
    logic sram_re;
    logic acc_end;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic [127:0] old;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n;

    ////////////////////////////////////////////////////////////////////////////
    // short run time keeps the bench quick; the 16-cycle timer still outlasts the engine
    bci_top #(.RUN_CYCLES(RUN)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sleep_i(sleep_i),
        .sram_we_i(sram_we), .sram_re_i(sram_re), .acc_end_i(acc_end),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .busy_o(busy)
    );
    bci_host_model i_host (
        .mclk_i(mclk_i), .rdata_i(rdata), .sram_we_o(sram_we), .sram_re_o(sram_re),
        .acc_end_o(acc_end), .addr_o(addr), .wdata_o(wdata)
    );

    // 200 MHz clock and a hang guard
    always #2.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr1(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_host.xfer(1'b1, a, d, q);
        i_host.close_acc();
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_host.xfer(1'b0, a, 8'h00, q);
        i_host.close_acc();
        `CHK(q, exp)
    endtask

    // all sixteen window bytes in one access, byte 0 most significant
    task automatic blkc(input logic [127:0] exp);
        logic [127:0] got;
        logic [7:0] q;
        for (int i = 0; i < 16; i++) begin
            i_host.xfer(1'b0, `BCI_ADDR_WIN_LO + i[7:0], 8'h00, q);
            got[127 - 8 * i -: 8] = q;
        end
        i_host.close_acc();
        `CHK(got, exp)
    endtask

    // control, window and control copy in one burst; keeps shifted-out bytes
    task automatic load_run(input logic [7:0] ctl, input logic [127:0] blk, input logic [7:0] cpy,
                            output logic [127:0] prev);
        logic [7:0] q;
        i_host.xfer(1'b1, `BCI_ADDR_CTRL, ctl, q);
        for (int i = 0; i < 16; i++) begin
            i_host.xfer(1'b1, `BCI_ADDR_WIN_LO + i[7:0], blk[127 - 8 * i -: 8], q);
            prev[127 - 8 * i -: 8] = q;
        end
        i_host.xfer(1'b1, `BCI_ADDR_MIRROR, cpy, q);
        i_host.close_acc();
    endtask

    // watches the busy pin only, so control is never touched mid-run
    task automatic wait_idle(output int cnt);
        cnt = 0;
        while (busy === 1'b1 && cnt < 200) begin
            @(posedge mclk_i);
            #1;
            cnt++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(`BCI_ADDR_STATUS, 8'h00);
        rdc(`BCI_ADDR_CTRL, 8'h00);
        rdc(8'h80, 8'h00);
        rdc(8'h95, 8'h00);
        wr1(`BCI_ADDR_STATUS, 8'hFF);
        rdc(`BCI_ADDR_STATUS, 8'h00);
        $display("test reset done");
    endtask

    // every mode and direction through both control addresses
    task automatic t_ctrl();
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 2; d++) begin
                wr1(d ? `BCI_ADDR_MIRROR : `BCI_ADDR_CTRL, {1'b0, m[2:0], d[0], 3'b111});
                rdc(d ? `BCI_ADDR_CTRL : `BCI_ADDR_MIRROR, {1'b0, m[2:0], d[0], 3'b000});
            end
            if (m != 0 && m != 2) begin
                wr1(`BCI_ADDR_CTRL, {1'b1, m[2:0], 4'h0});
                `CHK(busy, 1'b0)
            end
        end
        $display("test control done");
    endtask

    task automatic t_ecb();
        logic [7:0] q;
        load_run(8'h10, KEY, 8'h10, old);
        load_run(8'h00, PT, 8'h80, old);
        `CHK(old, 128'h0)
        `CHK(busy, 1'b1)
        rdc(`BCI_ADDR_STATUS, 8'h00);
        wait_idle(n);
        `CHK(n + 3, RUN)
        rdc(`BCI_ADDR_STATUS, 8'h01);
        blkc(CT);
        rdc(`BCI_ADDR_STATUS, 8'h01);
        for (int i = 0; i < 4; i++) begin
            i_host.xfer(1'b0, `BCI_ADDR_WIN_LO + i[7:0], 8'h00, q);
        end
        i_host.close_acc();
        rdc(`BCI_ADDR_STATUS, 8'h81);
        wr1(`BCI_ADDR_CTRL, 8'h10);
        blkc(LRK);
        load_run(8'h20, PT ^ CT, 8'hA0, old);
        `CHK(old, CT)
        rdc(`BCI_ADDR_STATUS, 8'h00);
        wait_idle(n);
        blkc(CT);
        load_run(8'h10, LRK, 8'h10, old);
        `CHK(old, LRK)
        load_run(8'h08, CT, 8'h88, old);
        wait_idle(n);
        blkc(PT);
        wr1(`BCI_ADDR_CTRL, 8'h10);
        blkc(KEY);
        $display("test cipher runs done");
    endtask

    task automatic t_abort();
        logic [7:0] q;
        load_run(8'h00, PT, 8'h80, old);
        i_host.xfer(1'b0, `BCI_ADDR_CTRL, 8'h00, q);
        i_host.close_acc();
        `CHK(q, 8'h80)
        `CHK(busy, 1'b0)
        rdc(`BCI_ADDR_STATUS, 8'h80);
        load_run(8'h00, PT, 8'h80, old);
        wr1(`BCI_ADDR_MIRROR, 8'h28);
        `CHK(busy, 1'b0)
        rdc(`BCI_ADDR_CTRL, 8'h00);
        $display("test abort done");
    endtask

    // sleep in mid-run must wipe every register
    task automatic t_sleep();
        load_run(8'h08, PT, 8'h88, old);
        sleep_i = 1'b1;
        @(posedge mclk_i);
        #1;
        sleep_i = 1'b0;
        `CHK(busy, 1'b0)
        rdc(`BCI_ADDR_STATUS, 8'h00);
        rdc(`BCI_ADDR_CTRL, 8'h00);
        blkc(128'h0);
        $display("test sleep done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk_i);
        #1;
        rst_n_i = 1'b1;
        t_reset();
        t_ctrl();
        t_ecb();
        t_abort();
        t_sleep();
        close_out();
    end
endmodule
`default_nettype wire
